// ### pkg/scp_pkg.sv
// Overview of operation
// - Enable low powers the device down; only signal detect keeps running.
// - Enable rising from power-down runs the power-on reset sequence first.
// - Lock-reference low locks clock recovery to the transmit reference clock.
// - Lock-reference low tri-states receive data, recovered clock and both K flags.
// - Lock-reference high makes the receiver track the incoming serial data.
// - Loopback high routes serialized transmit data into the receiver input.
// - During loopback the serial transmit outputs are high impedance.
// - Preemphasis select low gives 5 percent, high gives 20 percent.
// - With PRBS test enabled the low K flag shows the PRBS checker pass.
// - Otherwise the low K flag marks a K character in the lower byte.
// - The high K flag marks a K character in the upper byte.
// - Amplitude below 200 mV forces all receive data and both K flags high.
// - Recovered clock is bit rate over 20, synchronous with data and flags.
// - Recovered clock is held low throughout power-on reset.
// - Receive data is valid at the recovered clock rising edge.
// - Receive data outputs are high impedance during power-on reset.
package scp_pkg;

   // Register byte addresses
   localparam logic [7:0] SCP_CTRL_ADDR     = 8'h00;
   localparam logic [7:0] SCP_STATUS_ADDR   = 8'h04;
   localparam logic [7:0] SCP_INT_STAT_ADDR = 8'h08;
   localparam logic [7:0] SCP_INT_CLR_ADDR  = 8'h0c;
   localparam logic [7:0] SCP_INT_EN_ADDR   = 8'h10;

   // Control register fields
   localparam int SCP_CTRL_ENABLE   = 0;
   localparam int SCP_CTRL_LOCK_REF = 1;
   localparam int SCP_CTRL_LOOPBACK = 2;
   localparam int SCP_CTRL_PREEMPH  = 3;
   localparam int SCP_CTRL_PRBS     = 4;
   localparam int SCP_CTRL_W        = 5;
   localparam logic [SCP_CTRL_W-1:0] SCP_CTRL_RESET = 5'h03;

   // Status register fields
   localparam int SCP_ST_POWERED = 0;
   localparam int SCP_ST_IN_POR  = 1;
   localparam int SCP_ST_LOS     = 2;
   localparam int SCP_ST_PRBS_OK = 3;
   localparam int SCP_ST_W       = 4;

   // Interrupt event fields
   localparam int SCP_EV_POR_DONE  = 0;
   localparam int SCP_EV_LOS       = 1;
   localparam int SCP_EV_PRBS_FAIL = 2;
   localparam int SCP_EV_W         = 3;

   // Preemphasis levels, percent
   localparam logic [4:0] SCP_PREEMPH_LOW  = 5'h05;
   localparam logic [4:0] SCP_PREEMPH_HIGH = 5'h14;

   // Recovered clock: one word of 20 serial bits
   localparam int SCP_BITS_PER_WORD = 20;
   localparam int SCP_HALF_WORD     = SCP_BITS_PER_WORD / 2;

   // Power-on reset time
   localparam int SCP_CLK_PERIOD_NS = 20;
   localparam int SCP_POR_TIME_NS   = 10000;
   localparam int SCP_POR_CYCLES    =
      (SCP_POR_TIME_NS + SCP_CLK_PERIOD_NS - 1) / SCP_CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      SCP_OFF,
      SCP_POR,
      SCP_RUN
   } scp_state_t;

endpackage : scp_pkg

// ### design/scp_ctrl.sv
`timescale 1ns/10ps
module scp_ctrl #(
   parameter int POR_CYCLES = scp_pkg::SCP_POR_CYCLES
) (
   // Clock and reset
   input  wire logic                              clk_i,
   input  wire logic                              rst_i,
   // Wishbone slave
   input  wire logic                              wb_cyc_i,
   input  wire logic                              wb_stb_i,
   input  wire logic                              wb_we_i,
   input  wire logic [7:0]                        wb_adr_i,
   input  wire logic [3:0]                        wb_sel_i,
   input  wire logic [31:0]                       wb_dat_i,
   output logic      [31:0]                       wb_dat_o,
   output logic                                   wb_ack_o,
   output logic                                   irq_o,
   // Serial side
   input  wire logic                              bit_tick_i,
   input  wire logic                              tx_serial_bit_i,
   input  wire logic                              serial_in_pos_i,
   input  wire logic                              serial_in_neg_i,
   input  wire logic                              signal_lost_i,
   output logic                                   serial_out_pos_o,
   output logic                                   serial_out_neg_o,
   output logic                                   serial_out_oe_o,
   output logic                                   cdr_serial_o,
   output logic                                   cdr_lock_to_ref_o,
   output logic      [4:0]                        preemph_pct_o,
   output logic                                   core_power_o,
   output logic                                   sig_detect_power_o,
   // Decoder side
   input  wire logic [15:0]                       dec_data_i,
   input  wire logic [1:0]                        dec_k_i,
   input  wire logic                              prbs_ok_i,
   // Parallel receive pins
   output logic      [15:0]                       rx_data_o,
   output logic                                   rx_data_oe_o,
   output logic                                   low_byte_k_flag_o,
   output logic                                   high_byte_k_flag_o,
   output logic                                   k_flags_oe_o,
   output logic                                   recovered_clock_o,
   output logic                                   recovered_clock_oe_o
);
   import scp_pkg::*;

   localparam int PCW = $clog2(POR_CYCLES + 1);
   localparam int WCW = $clog2(SCP_BITS_PER_WORD);
   localparam logic [PCW-1:0] POR_LAST  = PCW'(POR_CYCLES - 1);
   localparam logic [WCW-1:0] WORD_LAST = WCW'(SCP_BITS_PER_WORD - 1);
   localparam logic [WCW-1:0] WORD_HALF = WCW'(SCP_HALF_WORD);

   ////////////////////////////////////////////////////////////////////////////
   // Register bus

   logic [SCP_CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [SCP_EV_W-1:0]   int_stat_q, int_stat_d;
   logic [SCP_EV_W-1:0]   int_en_q, int_en_d;
   logic [SCP_EV_W-1:0]   events;
   logic [31:0]           dat_d;
   logic                  ack_d;
   logic                  irq_d;
   logic                  wr_lo;
   logic [SCP_ST_W-1:0]   status;
   scp_state_t            state_q, state_d;
   logic                  los_q, prbs_q;

   // Only byte lane 0 carries register bits
   assign wr_lo = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

   always_comb begin
      status                 = '0;
      status[SCP_ST_POWERED] = (state_q == SCP_RUN);
      status[SCP_ST_IN_POR]  = (state_q == SCP_POR);
      status[SCP_ST_LOS]     = los_q;
      status[SCP_ST_PRBS_OK] = prbs_q;
   end

   always_comb begin
      ctrl_d     = ctrl_q;
      int_en_d   = int_en_q;
      int_stat_d = int_stat_q;
      ack_d      = wb_cyc_i && wb_stb_i && !wb_ack_o;
      dat_d      = '0;
      if (wr_lo && wb_adr_i == SCP_CTRL_ADDR) begin
         ctrl_d = wb_dat_i[SCP_CTRL_W-1:0];
      end else if (wr_lo && wb_adr_i == SCP_INT_EN_ADDR) begin
         int_en_d = wb_dat_i[SCP_EV_W-1:0];
      end else if (wr_lo && wb_adr_i == SCP_INT_CLR_ADDR) begin
         int_stat_d = int_stat_q & ~wb_dat_i[SCP_EV_W-1:0];
      end
      // New events win over a clear in the same cycle
      int_stat_d = int_stat_d | events;
      if (wb_adr_i == SCP_CTRL_ADDR) begin
         dat_d[SCP_CTRL_W-1:0] = ctrl_q;
      end else if (wb_adr_i == SCP_STATUS_ADDR) begin
         dat_d[SCP_ST_W-1:0] = status;
      end else if (wb_adr_i == SCP_INT_STAT_ADDR) begin
         dat_d[SCP_EV_W-1:0] = int_stat_q;
      end else if (wb_adr_i == SCP_INT_EN_ADDR) begin
         dat_d[SCP_EV_W-1:0] = int_en_q;
      end
      if (!ack_d || wb_we_i) begin
         dat_d = '0;
      end
      irq_d = |(int_stat_d & int_en_d);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q     <= SCP_CTRL_RESET;
         int_stat_q <= '0;
         int_en_q   <= '0;
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= '0;
         irq_o      <= 1'b0;
      end else begin
         ctrl_q     <= ctrl_d;
         int_stat_q <= int_stat_d;
         int_en_q   <= int_en_d;
         wb_ack_o   <= ack_d;
         wb_dat_o   <= dat_d;
         irq_o      <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power state and power-on reset

   logic [PCW-1:0] por_cnt_q, por_cnt_d;
   logic           en;

   assign en = ctrl_q[SCP_CTRL_ENABLE];

   always_comb begin
      state_d   = state_q;
      por_cnt_d = por_cnt_q;
      case (state_q)
         SCP_OFF: begin
            por_cnt_d = '0;
            if (en) begin
               state_d = SCP_POR;
            end
         end
         SCP_POR: begin
            por_cnt_d = por_cnt_q + PCW'(1);
            if (!en) begin
               state_d = SCP_OFF;
            end else if (por_cnt_q == POR_LAST) begin
               state_d = SCP_RUN;
            end
         end
         default: begin
            if (!en) begin
               state_d = SCP_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q   <= SCP_POR;
         por_cnt_q <= '0;
      end else begin
         state_q   <= state_d;
         por_cnt_q <= por_cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial path controls

   logic run, lock_ref_n, loop;
   logic ser_pos_d, ser_oe_d, cdr_d, pwr_d;
   logic [4:0] pre_d;

   assign run        = (state_q == SCP_RUN);
   assign lock_ref_n = ctrl_q[SCP_CTRL_LOCK_REF];
   // Loopback only in self-test; normal use expects it low
   assign loop       = ctrl_q[SCP_CTRL_LOOPBACK];

   always_comb begin
      pwr_d     = (state_q != SCP_OFF);
      cdr_d     = loop ? tx_serial_bit_i : serial_in_pos_i;
      ser_oe_d  = run && !loop;
      ser_pos_d = tx_serial_bit_i;
      pre_d     = ctrl_q[SCP_CTRL_PREEMPH] ? SCP_PREEMPH_HIGH : SCP_PREEMPH_LOW;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_out_pos_o   <= 1'b0;
         serial_out_neg_o   <= 1'b1;
         serial_out_oe_o    <= 1'b0;
         cdr_serial_o       <= 1'b0;
         cdr_lock_to_ref_o  <= 1'b0;
         preemph_pct_o      <= SCP_PREEMPH_LOW;
         core_power_o       <= 1'b0;
         sig_detect_power_o <= 1'b0;
      end else begin
         serial_out_pos_o   <= ser_pos_d;
         serial_out_neg_o   <= !ser_pos_d;
         serial_out_oe_o    <= ser_oe_d;
         cdr_serial_o       <= cdr_d;
         cdr_lock_to_ref_o  <= !lock_ref_n;
         preemph_pct_o      <= pre_d;
         core_power_o       <= pwr_d;
         // Signal detect stays alive even in power-down
         sig_detect_power_o <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Recovered clock and receive word

   logic [WCW-1:0] bit_cnt_q, bit_cnt_d;
   logic [15:0]    rxd_d;
   logic           kl_d, kh_d, rclk_d, rx_oe_d, rclk_oe_d;
   logic           launch;
   logic           los_d, prbs_d;

   // Launch at the falling edge so data is settled at the next rise
   assign launch = run && bit_tick_i && (bit_cnt_q == WORD_LAST);

   always_comb begin
      bit_cnt_d = bit_cnt_q;
      if (!run) begin
         bit_cnt_d = '0;
      end else if (bit_tick_i) begin
         bit_cnt_d = (bit_cnt_q == WORD_LAST) ? '0 : bit_cnt_q + WCW'(1);
      end
      rclk_d = run && (bit_cnt_d >= WORD_HALF);
      rxd_d  = rx_data_o;
      kl_d   = low_byte_k_flag_o;
      kh_d   = high_byte_k_flag_o;
      if (launch) begin
         if (signal_lost_i) begin
            rxd_d = '1;
            kl_d  = 1'b1;
            kh_d  = 1'b1;
         end else begin
            rxd_d = dec_data_i;
            kl_d  = ctrl_q[SCP_CTRL_PRBS] ? prbs_ok_i : dec_k_i[0];
            kh_d  = dec_k_i[1];
         end
      end
      rx_oe_d   = run && lock_ref_n;
      rclk_oe_d = lock_ref_n;
      los_d     = signal_lost_i;
      prbs_d    = ctrl_q[SCP_CTRL_PRBS] && prbs_ok_i;
      events                   = '0;
      events[SCP_EV_POR_DONE]  = (state_q == SCP_POR) && (state_d == SCP_RUN);
      events[SCP_EV_LOS]       = signal_lost_i && !los_q;
      events[SCP_EV_PRBS_FAIL] = prbs_q && !prbs_d;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_cnt_q            <= '0;
         recovered_clock_o    <= 1'b0;
         recovered_clock_oe_o <= 1'b0;
         rx_data_o            <= '0;
         rx_data_oe_o         <= 1'b0;
         low_byte_k_flag_o    <= 1'b0;
         high_byte_k_flag_o   <= 1'b0;
         k_flags_oe_o         <= 1'b0;
         los_q                <= 1'b0;
         prbs_q               <= 1'b0;
      end else begin
         bit_cnt_q            <= bit_cnt_d;
         recovered_clock_o    <= rclk_d;
         recovered_clock_oe_o <= rclk_oe_d;
         rx_data_o            <= rxd_d;
         rx_data_oe_o         <= rx_oe_d;
         low_byte_k_flag_o    <= kl_d;
         high_byte_k_flag_o   <= kh_d;
         k_flags_oe_o         <= rx_oe_d;
         los_q                <= los_d;
         prbs_q               <= prbs_d;
      end
   end

endmodule : scp_ctrl

// ### testbench/scp_ctrl_assertions.sv
`timescale 1ns/10ps
module scp_chk #(
   parameter int POR_CYCLES = 4
) (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // Bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   // Serial and power
   input wire logic        signal_lost_i,
   input wire logic        core_power_o,
   input wire logic        sig_detect_power_o,
   input wire logic        cdr_lock_to_ref_o,
   input wire logic [4:0]  preemph_pct_o,
   // Receive pins
   input wire logic [15:0] rx_data_o,
   input wire logic        rx_data_oe_o,
   input wire logic        low_byte_k_flag_o,
   input wire logic        high_byte_k_flag_o,
   input wire logic        k_flags_oe_o,
   input wire logic        recovered_clock_o,
   input wire logic        recovered_clock_oe_o
);
   import scp_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("request not acked next cycle");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_pwr_down;
      !core_power_o && !$past(rst_i) |-> sig_detect_power_o && !recovered_clock_o;
   endproperty
   a_pwr_down: assert property (p_pwr_down) else $error("power-down state wrong");
   property p_lock_hiz;
      cdr_lock_to_ref_o |-> !rx_data_oe_o && !k_flags_oe_o && !recovered_clock_oe_o;
   endproperty
   a_lock_hiz: assert property (p_lock_hiz) else $error("receive pins driven");
   property p_preemph;
      preemph_pct_o == SCP_PREEMPH_LOW || preemph_pct_o == SCP_PREEMPH_HIGH;
   endproperty
   a_preemph: assert property (p_preemph) else $error("bad preemphasis level");
   // Word launched one edge before the fall, with loss seen at that edge
   property p_los_ones;
      $fell(recovered_clock_o) && core_power_o && $past(signal_lost_i)
         |-> &{rx_data_o, low_byte_k_flag_o, high_byte_k_flag_o};
   endproperty
   a_los_ones: assert property (p_los_ones) else $error("loss did not force ones");
   property p_rclk_high;
      $fell(recovered_clock_o) && core_power_o
         |-> $past(recovered_clock_o, 10) && !$past(recovered_clock_o, 11);
   endproperty
   a_rclk_high: assert property (p_rclk_high) else $error("clock high phase wrong");
   property p_data_hold;
      recovered_clock_o |-> $stable(rx_data_o) && $stable(low_byte_k_flag_o);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("data moved while clock high");

   c_los: cover property ($fell(recovered_clock_o) && signal_lost_i);
   c_ack: cover property (wb_ack_o);
   c_lock: cover property (cdr_lock_to_ref_o);
endmodule : scp_chk

bind scp_ctrl scp_chk #(.POR_CYCLES(POR_CYCLES)) i_scp_chk (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .signal_lost_i, .core_power_o,
   .sig_detect_power_o, .cdr_lock_to_ref_o, .preemph_pct_o, .rx_data_o, .rx_data_oe_o,
   .low_byte_k_flag_o, .high_byte_k_flag_o, .k_flags_oe_o, .recovered_clock_o,
   .recovered_clock_oe_o
);

// ### testbench/scp_proto_model.sv
`timescale 1ns/10ps
module scp_proto_model (
   // Receive pins as seen on the board
   input  wire logic        rclk_i,
   input  wire logic [15:0] rxd_i,
   input  wire logic        kl_i,
   input  wire logic        kh_i,
   // Last captured word
   output logic      [17:0] word_o
);
   // Undriven pins come in as z, so a released bus never passes for data
   always @(posedge rclk_i) begin
      word_o <= {kh_i, kl_i, rxd_i};
   end
endmodule : scp_proto_model

// ### testbench/scp_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_count++; \
   $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module scp_ctrl_tb;
   import scp_pkg::*;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, bit_tick_i, tx_serial_bit_i;
   logic        serial_in_pos_i, signal_lost_i, prbs_ok_i, wb_ack_o, irq_o, serial_out_oe_o;
   logic        cdr_serial_o, cdr_lock_to_ref_o, core_power_o, sig_detect_power_o;
   logic        rx_data_oe_o, low_byte_k_flag_o, high_byte_k_flag_o, k_flags_oe_o;
   logic        recovered_clock_o, recovered_clock_oe_o;
   logic        serial_out_pos_o, serial_out_neg_o;
   logic [3:0]  wb_sel_i;
   logic [7:0]  wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [15:0] dec_data_i, rx_data_o;
   logic [1:0]  dec_k_i;
   logic [4:0]  preemph_pct_o;
   logic [17:0] word;
   int          err_count = 0, n_checks = 0, cycles = 0;

   scp_ctrl #(.POR_CYCLES(4)) i_scp_ctrl (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .irq_o, .bit_tick_i, .tx_serial_bit_i, .serial_in_pos_i,
      .serial_in_neg_i(1'b0), .signal_lost_i, .serial_out_pos_o, .serial_out_neg_o,
      .serial_out_oe_o, .cdr_serial_o, .cdr_lock_to_ref_o, .preemph_pct_o, .core_power_o,
      .sig_detect_power_o, .dec_data_i, .dec_k_i, .prbs_ok_i, .rx_data_o, .rx_data_oe_o,
      .low_byte_k_flag_o, .high_byte_k_flag_o, .k_flags_oe_o, .recovered_clock_o,
      .recovered_clock_oe_o
   );
   scp_proto_model i_scp_proto_model (
      .rclk_i(recovered_clock_oe_o ? recovered_clock_o : 1'bz),
      .rxd_i(rx_data_oe_o ? rx_data_o : 16'hzzzz),
      .kl_i(k_flags_oe_o ? low_byte_k_flag_o : 1'bz),
      .kh_i(k_flags_oe_o ? high_byte_k_flag_o : 1'bz),
      .word_o(word)
   );

   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         results();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // No limit here; the cycle ceiling ends a hung request
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick

   task results;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      bit_tick_i = 1'b1;
      wb_sel_i = 4'hf;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, tx_serial_bit_i, serial_in_pos_i,
       signal_lost_i, prbs_ok_i, dec_data_i, dec_k_i} = '0;
      tick(10);
      rst_i <= 1'b0;
      tick(1);
      wb(0, SCP_CTRL_ADDR, 0);
      `CHK("ctrl", 32'h3, rd)
      `CHK("preemph", SCP_PREEMPH_LOW, preemph_pct_o)
      // Write without byte lane 0 must leave the controls alone
      wb_sel_i <= 4'he;
      wb(1, SCP_CTRL_ADDR, 0);
      wb_sel_i <= 4'hf;
      wb(0, SCP_CTRL_ADDR, 0);
      `CHK("ctrl kept", 32'h3, rd)
      wb(0, 8'h20, 0);
      `CHK("unmapped", 32'h0, rd)
      tick(8);
      wb(0, SCP_STATUS_ADDR, 0);
      `CHK("running", 1'b1, rd[SCP_ST_POWERED])
      `CHK("tracking", 1'b0, cdr_lock_to_ref_o)
      $display("done: reset");
      wb(0, SCP_INT_STAT_ADDR, 0);
      `CHK("por event", 1'b1, rd[SCP_EV_POR_DONE])
      wb(1, SCP_INT_EN_ADDR, 32'h1);
      tick(2);
      `CHK("irq set", 1'b1, irq_o)
      wb(1, SCP_INT_EN_ADDR, 32'h0);
      tick(2);
      `CHK("irq masked", 1'b0, irq_o)
      wb(1, SCP_INT_EN_ADDR, 32'h1);
      wb(1, SCP_INT_CLR_ADDR, 32'h1);
      tick(2);
      `CHK("irq cleared", 1'b0, irq_o)
      $display("done: interrupts");
      for (int k = 0; k < 4; k++) begin
         dec_k_i <= k[1:0];
         dec_data_i <= {4{k[3:0]}};
         tick(45);
         `CHK("word", {k[1:0], {4{k[3:0]}}}, word)
      end
      wb(1, SCP_CTRL_ADDR, 32'h13);
      for (int p = 0; p < 2; p++) begin
         prbs_ok_i <= p[0];
         dec_k_i <= {1'b0, ~p[0]};
         tick(45);
         `CHK("prbs flag", p[0], word[16])
      end
      wb(1, SCP_CTRL_ADDR, 32'h3);
      signal_lost_i <= 1'b1;
      tick(45);
      `CHK("loss word", 18'h3ffff, word)
      wb(0, SCP_STATUS_ADDR, 0);
      `CHK("loss status", 4'h5, rd[SCP_ST_W-1:0])
      wb(0, SCP_INT_STAT_ADDR, 0);
      `CHK("loss events", 3'h6, rd[SCP_EV_W-1:0])
      signal_lost_i <= 1'b0;
      $display("done: receive");
      // Loopback with high preemphasis; line input held opposite to tx
      wb(1, SCP_CTRL_ADDR, 32'hf);
      tx_serial_bit_i <= 1'b1;
      tick(3);
      `CHK("preemph", SCP_PREEMPH_HIGH, preemph_pct_o)
      `CHK("tx oe", 1'b0, serial_out_oe_o)
      `CHK("loop bit", 1'b1, cdr_serial_o)
      wb(1, SCP_CTRL_ADDR, 32'h3);
      tick(3);
      `CHK("line bit", 1'b0, cdr_serial_o)
      `CHK("tx oe", 1'b1, serial_out_oe_o)
      `CHK("tx pair", 2'b10, {serial_out_pos_o, serial_out_neg_o})
      wb(1, SCP_CTRL_ADDR, 32'h1);
      tick(3);
      `CHK("rx oe", 3'b000, {rx_data_oe_o, k_flags_oe_o, recovered_clock_oe_o})
      `CHK("ref lock", 1'b1, cdr_lock_to_ref_o)
      $display("done: modes");
      wb(1, SCP_CTRL_ADDR, 32'h2);
      tick(3);
      `CHK("off", 3'b010, {core_power_o, sig_detect_power_o, recovered_clock_o})
      wb(1, SCP_CTRL_ADDR, 32'h3);
      `CHK("por pins", 2'b00, {rx_data_oe_o, recovered_clock_o})
      tick(30);
      `CHK("resumed", 1'b1, rx_data_oe_o)
      $display("done: power");
      results();
   end
endmodule : scp_ctrl_tb
